//--- exit_fault_pkg.sv
// constants for the enclave exit fault record block
package exit_fault_pkg;
    localparam logic [7:0] VEC_DIVIDE = 8'h00;
    localparam logic [7:0] VEC_DEBUG = 8'h01;
    localparam logic [7:0] VEC_BREAKPOINT = 8'h03;
    localparam logic [7:0] VEC_BOUND = 8'h05;
    localparam logic [7:0] VEC_INVALID_OP = 8'h06;
    localparam logic [7:0] VEC_GEN_PROT = 8'h0d;
    localparam logic [7:0] VEC_PAGE_FAULT = 8'h0e;
    localparam logic [7:0] VEC_X87 = 8'h10;
    localparam logic [7:0] VEC_ALIGN = 8'h11;
    localparam logic [7:0] VEC_SIMD = 8'h13;
    localparam logic [7:0] VEC_CTRL_PROT = 8'h15;
    localparam logic [2:0] TYPE_HW = 3'h3;
    localparam logic [2:0] TYPE_SW = 3'h6;
    localparam int VALID_BIT = 31;
    localparam int SEL_DETAIL_BIT = 0;
    localparam int SEL_CP_BIT = 1;
    localparam int ERR_US_BIT = 2;
    localparam logic [15:0] DETAIL_SIZE = 16'h0010;
    localparam logic [63:0] DETAIL_ADDR_OFS = 64'h0;
    localparam logic [63:0] DETAIL_ERR_OFS = 64'h8;
    localparam logic [63:0] DETAIL_RSV_OFS = 64'hc;
    localparam logic [63:0] FLOW_SSP_OFS = 64'h0;
    localparam logic [63:0] FLOW_TRK_OFS = 64'h8;
    localparam logic [63:0] FLOW_FRAME_SIZE = 64'h10;
    localparam logic [63:0] PAGE_INFO_ALIGN_MASK = 64'h1f;
    localparam logic [63:0] PI_LINEAR_OFS = 64'h0;
    localparam logic [63:0] PI_SOURCE_OFS = 64'h8;
    localparam logic [63:0] PI_META_OFS = 64'h10;
    localparam logic [63:0] PI_CTRL_PAGE_OFS = 64'h18;
    localparam logic [31:0] EXIT_WORD_RESET = 32'h0;
endpackage : exit_fault_pkg

//--- mem_write_if.sv
// write port carrying frame stores between the sequencer and the writer
interface mem_write_if;
    logic req;
    logic [63:0] addr;
    logic [63:0] data;
    logic [3:0] size_bytes;
    modport src (output req, output addr, output data, output size_bytes);
    modport dst (input req, input addr, input data, input size_bytes);
endinterface : mem_write_if

//--- frame_writer.sv
// registers one frame store onto the memory write port
module frame_writer (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    mem_write_if.dst wr,
    output logic mem_wr_out,
    output logic [63:0] mem_addr_out,
    output logic [63:0] mem_data_out,
    output logic [3:0] mem_size_out
);
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            mem_wr_out <= 1'b0;
            mem_addr_out <= 64'h0;
            mem_data_out <= 64'h0;
            mem_size_out <= 4'h0;
        end
        else
        begin
            mem_wr_out <= wr.req;
            if (wr.req)
            begin
                mem_addr_out <= wr.addr;
                mem_data_out <= wr.data;
                mem_size_out <= wr.size_bytes;
            end
        end
    end
endmodule : frame_writer

//--- enclave_exit_fault_record.sv
// builds exit word, fault detail and control-flow frame on an exit
//
// Added by the designer: the register offsets and the plain strobed port.
module enclave_exit_fault_record (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic exit_start_in,
    input wire logic [7:0] vector_in,
    input wire logic software_exc_in,
    input wire logic [31:0] fault_error_code_in,
    input wire logic [63:0] fault_linear_address_in,
    input wire logic [31:0] ext_capability_in,
    input wire logic [31:0] component_select_mask_in,
    input wire logic [63:0] general_register_region_in,
    input wire logic shadow_stack_supported_in,
    input wire logic branch_tracker_supported_in,
    input wire logic [63:0] shadow_stack_pointer_in,
    input wire logic tracker_suppressed_in,
    input wire logic awaiting_branch_target_in,
    input wire logic [31:0] frame_count_in,
    input wire logic [31:0] current_frame_index_in,
    input wire logic [63:0] flow_area_offset_in,
    input wire logic [63:0] page_info_base_in,
    output logic page_info_aligned_out,
    output logic [63:0] page_info_linear_addr_out,
    output logic [63:0] page_info_source_addr_out,
    output logic [63:0] page_info_meta_addr_out,
    output logic [63:0] page_info_ctrl_page_addr_out,
    output logic [31:0] exit_info_word_out,
    output logic ext_region_supported_out,
    output logic [15:0] ext_region_size_out,
    output logic [63:0] ext_region_base_out,
    output logic busy_out,
    output logic done_out,
    output logic mem_wr_out,
    output logic [63:0] mem_addr_out,
    output logic [63:0] mem_data_out,
    output logic [3:0] mem_size_out
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ERR = 3'b011,
        ST_RSV = 3'b010,
        ST_SSP = 3'b110,
        ST_TRK = 3'b111,
        ST_DONE = 3'b101
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic [7:0] vec_reg;
    logic type_sw_reg;
    logic [31:0] err_reg;
    logic [63:0] lin_reg;
    logic [31:0] sel_reg;
    logic [31:0] cap_reg;
    logic [63:0] gpr_reg;
    logic ss_sup_reg;
    logic ibt_sup_reg;
    logic [63:0] ssp_reg;
    logic [1:0] trk_reg;
    logic [63:0] flow_base_reg;
    logic record_detail_reg;
    logic flow_ok_reg;

    logic detail_ok;
    logic cp_ok;
    logic reportable;
    logic record_detail;
    logic [63:0] frame_base;
    logic [63:0] detail_base;
    logic [4:0] top_sel;
    logic flow_valid;

    mem_write_if wr_bus ();

    ////////////////////////////////////////////////////////////////////////
    // capability and select must both be set for each detail class
    assign detail_ok = cap_reg[exit_fault_pkg::SEL_DETAIL_BIT]
        & sel_reg[exit_fault_pkg::SEL_DETAIL_BIT];
    assign cp_ok = cap_reg[exit_fault_pkg::SEL_CP_BIT]
        & sel_reg[exit_fault_pkg::SEL_CP_BIT];

    always_comb
    begin
        unique case (vec_reg)
            exit_fault_pkg::VEC_DIVIDE, exit_fault_pkg::VEC_DEBUG,
            exit_fault_pkg::VEC_BREAKPOINT, exit_fault_pkg::VEC_BOUND,
            exit_fault_pkg::VEC_INVALID_OP:
                reportable = 1'b1;
            exit_fault_pkg::VEC_X87, exit_fault_pkg::VEC_ALIGN,
            exit_fault_pkg::VEC_SIMD:
                reportable = 1'b1;
            exit_fault_pkg::VEC_GEN_PROT:
                reportable = sel_reg[exit_fault_pkg::SEL_DETAIL_BIT];
            exit_fault_pkg::VEC_PAGE_FAULT:
                reportable = sel_reg[exit_fault_pkg::SEL_DETAIL_BIT];
            exit_fault_pkg::VEC_CTRL_PROT:
                reportable = sel_reg[exit_fault_pkg::SEL_CP_BIT];
            default:
                reportable = 1'b0;
        endcase
    end

    always_comb
    begin
        record_detail = 1'b0;
        if (vec_reg == exit_fault_pkg::VEC_GEN_PROT)
            record_detail = detail_ok;
        else if (vec_reg == exit_fault_pkg::VEC_PAGE_FAULT)
            record_detail = detail_ok
                & err_reg[exit_fault_pkg::ERR_US_BIT];
        else if (vec_reg == exit_fault_pkg::VEC_CTRL_PROT)
            record_detail = cp_ok;
    end

    // highest set select bit sizes the region; only component 0 is defined
    always_comb
    begin
        top_sel = 5'h0;
        for (int i = 0; i < 32; i++)
        begin
            if (sel_reg[i])
                top_sel = 5'(i);
        end
    end

    assign detail_base = gpr_reg - 64'(exit_fault_pkg::DETAIL_SIZE);
    assign frame_base = flow_area_offset_in
        + 64'(current_frame_index_in) * exit_fault_pkg::FLOW_FRAME_SIZE;
    assign flow_valid = (frame_count_in != 32'h0)
        && (current_frame_index_in < frame_count_in);

    ////////////////////////////////////////////////////////////////////////
    // capture all exit inputs (not page_info_base_in) on the start pulse so the sequence is self-contained
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            vec_reg <= 8'h00;
            type_sw_reg <= 1'b0;
            err_reg <= 32'h0;
            lin_reg <= 64'h0;
            sel_reg <= 32'h0;
            cap_reg <= 32'h0;
            gpr_reg <= 64'h0;
            ss_sup_reg <= 1'b0;
            ibt_sup_reg <= 1'b0;
            ssp_reg <= 64'h0;
            trk_reg <= 2'h0;
            flow_base_reg <= 64'h0;
            flow_ok_reg <= 1'b0;
        end
        else if (exit_start_in && state_reg == ST_IDLE)
        begin
            vec_reg <= vector_in;
            type_sw_reg <= software_exc_in;
            err_reg <= fault_error_code_in;
            lin_reg <= fault_linear_address_in;
            sel_reg <= component_select_mask_in;
            cap_reg <= ext_capability_in;
            gpr_reg <= general_register_region_in;
            ss_sup_reg <= shadow_stack_supported_in;
            ibt_sup_reg <= branch_tracker_supported_in;
            ssp_reg <= shadow_stack_pointer_in;
            trk_reg <= {awaiting_branch_target_in,
                tracker_suppressed_in};
            flow_base_reg <= frame_base;
            flow_ok_reg <= flow_valid;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            record_detail_reg <= 1'b0;
        else if (state_reg == ST_IDLE)
            record_detail_reg <= 1'b0;
        else if (state_reg == ST_ADDR)
            record_detail_reg <= record_detail;
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
                if (exit_start_in)
                    state_next = ST_ADDR;
            ST_ADDR:
                state_next = record_detail ? ST_ERR : ST_SSP;
            ST_ERR:
                state_next = ST_RSV;
            ST_RSV:
                state_next = ST_SSP;
            ST_SSP:
                state_next = ST_TRK;
            ST_TRK:
                state_next = ST_DONE;
            ST_DONE:
                state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // stores issued only while sequencing, i.e. inside the exit
    always_comb
    begin
        wr_bus.req = 1'b0;
        wr_bus.addr = 64'h0;
        wr_bus.data = 64'h0;
        wr_bus.size_bytes = 4'h0;
        unique case (state_reg)
            ST_ADDR:
            begin
                wr_bus.req = record_detail;
                wr_bus.addr = detail_base + exit_fault_pkg::DETAIL_ADDR_OFS;
                wr_bus.data = (vec_reg == exit_fault_pkg::VEC_PAGE_FAULT)
                    ? lin_reg : 64'h0;
                wr_bus.size_bytes = 4'h8;
            end
            ST_ERR:
            begin
                wr_bus.req = record_detail_reg;
                wr_bus.addr = detail_base + exit_fault_pkg::DETAIL_ERR_OFS;
                wr_bus.data = {32'h0, err_reg};
                wr_bus.size_bytes = 4'h4;
            end
            ST_RSV:
            begin
                wr_bus.req = record_detail_reg;
                wr_bus.addr = detail_base + exit_fault_pkg::DETAIL_RSV_OFS;
                wr_bus.data = 64'h0;
                wr_bus.size_bytes = 4'h4;
            end
            ST_SSP:
            begin
                // reserved field left untouched when feature absent
                wr_bus.req = flow_ok_reg & ss_sup_reg;
                wr_bus.addr = flow_base_reg + exit_fault_pkg::FLOW_SSP_OFS;
                wr_bus.data = ssp_reg;
                wr_bus.size_bytes = 4'h8;
            end
            ST_TRK:
            begin
                wr_bus.req = flow_ok_reg & ibt_sup_reg;
                wr_bus.addr = flow_base_reg + exit_fault_pkg::FLOW_TRK_OFS;
                wr_bus.data = {62'h0, trk_reg};
                wr_bus.size_bytes = 4'h8;
            end
            default:
                wr_bus.req = 1'b0;
        endcase
    end

    frame_writer u_writer (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .wr(wr_bus),
        .mem_wr_out(mem_wr_out),
        .mem_addr_out(mem_addr_out),
        .mem_data_out(mem_data_out),
        .mem_size_out(mem_size_out)
    );

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            exit_info_word_out <= exit_fault_pkg::EXIT_WORD_RESET;
        else if (state_reg == ST_ADDR)
        begin
            exit_info_word_out <= exit_fault_pkg::EXIT_WORD_RESET;
            if (reportable)
            begin
                exit_info_word_out[7:0] <= vec_reg;
                exit_info_word_out[10:8] <= type_sw_reg
                    ? exit_fault_pkg::TYPE_SW
                    : exit_fault_pkg::TYPE_HW;
                exit_info_word_out[exit_fault_pkg::VALID_BIT] <= 1'b1;
            end // else fields stay clear
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ext_region_supported_out <= 1'b0;
            ext_region_size_out <= 16'h0;
            ext_region_base_out <= 64'h0;
        end
        else if (state_reg == ST_ADDR)
        begin
            ext_region_supported_out <= (cap_reg != 32'h0);
            if (cap_reg != 32'h0 && sel_reg != 32'h0 && top_sel == 5'h0)
            begin
                ext_region_size_out <= exit_fault_pkg::DETAIL_SIZE;
                ext_region_base_out <= detail_base;
            end
            else
            begin
                ext_region_size_out <= 16'h0;
                ext_region_base_out <= gpr_reg;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end
        else
        begin
            busy_out <= (state_next != ST_IDLE);
            done_out <= (state_reg == ST_DONE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // page info block decoding; alignment is software's duty, only flagged
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            page_info_aligned_out <= 1'b0;
            page_info_linear_addr_out <= 64'h0;
            page_info_source_addr_out <= 64'h0;
            page_info_meta_addr_out <= 64'h0;
            page_info_ctrl_page_addr_out <= 64'h0;
        end
        else
        begin
            page_info_aligned_out <= (page_info_base_in
                & exit_fault_pkg::PAGE_INFO_ALIGN_MASK) == 64'h0;
            page_info_linear_addr_out <= page_info_base_in
                + exit_fault_pkg::PI_LINEAR_OFS;
            page_info_source_addr_out <= page_info_base_in
                + exit_fault_pkg::PI_SOURCE_OFS;
            page_info_meta_addr_out <= page_info_base_in
                + exit_fault_pkg::PI_META_OFS;
            page_info_ctrl_page_addr_out <= page_info_base_in
                + exit_fault_pkg::PI_CTRL_PAGE_OFS;
        end
    end
endmodule : enclave_exit_fault_record

//--- enclave_exit_fault_record_assertions.sv
// concurrent checks on the exit fault record block ports
module enclave_exit_fault_record_assertions (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic exit_start_in,
    input wire logic [31:0] ext_capability_in,
    input wire logic [31:0] component_select_mask_in,
    input wire logic [63:0] general_register_region_in,
    input wire logic [63:0] page_info_base_in,
    input wire logic page_info_aligned_out,
    input wire logic [63:0] page_info_linear_addr_out,
    input wire logic [63:0] page_info_source_addr_out,
    input wire logic [63:0] page_info_meta_addr_out,
    input wire logic [63:0] page_info_ctrl_page_addr_out,
    input wire logic [31:0] exit_info_word_out,
    input wire logic ext_region_supported_out,
    input wire logic [15:0] ext_region_size_out,
    input wire logic [63:0] ext_region_base_out,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic mem_wr_out,
    input wire logic [3:0] mem_size_out
);
////////////////////////////////////////
timeunit 1ns;
timeprecision 100ps;
default clocking cb @(posedge ref_clk_in);
endclocking
default disable iff (!rstn_in);
logic start_d_reg, past_ok_reg, taken;
logic [63:0] base_d_reg;
// a start right after a start is not a new request
assign taken = exit_start_in && !busy_out && !start_d_reg;
always_ff @(posedge ref_clk_in or negedge rstn_in)
begin
    if (!rstn_in)
    begin
        start_d_reg <= 1'b0;
        past_ok_reg <= 1'b0;
        base_d_reg <= 64'h0;
    end
    else
    begin
        start_d_reg <= exit_start_in;
        past_ok_reg <= 1'b1;
        base_d_reg <= page_info_base_in;
    end
end
////////////////////////////////////////
property p_taken_busy;
    taken |=> busy_out;
endproperty
a_taken_busy: assert property (p_taken_busy)
    else $error("busy not raised");
property p_taken_done;
    taken |-> ##[4:10] done_out;
endproperty
a_taken_done: assert property (p_taken_done)
    else $error("exit not finished");
property p_store_in_seq;
    mem_wr_out |-> busy_out || done_out || $past(busy_out);
endproperty
a_store_in_seq: assert property (p_store_in_seq)
    else $error("store outside exit");
property p_word_fields;
    exit_info_word_out[31] |-> exit_info_word_out[30:11] == 20'h0 &&
        exit_info_word_out[10:8] inside {3'h3, 3'h6};
endproperty
a_word_fields: assert property (p_word_fields)
    else $error("exit word fields wrong");
property p_word_clear;
    !exit_info_word_out[31] |-> exit_info_word_out[10:0] == 11'h0;
endproperty
a_word_clear: assert property (p_word_clear)
    else $error("exit word not cleared");
property p_vec_set;
    exit_info_word_out[31] |-> exit_info_word_out[7:0] inside {8'h00,
        8'h01, 8'h03, 8'h05, 8'h06, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h13,
        8'h15};
endproperty
a_vec_set: assert property (p_vec_set)
    else $error("vector not reportable");
property p_region_sup;
    done_out |-> ext_region_supported_out == (ext_capability_in != 32'h0);
endproperty
a_region_sup: assert property (p_region_sup)
    else $error("region support wrong");
property p_region_size;
    done_out |-> ext_region_size_out == ((ext_capability_in != 32'h0 &&
        component_select_mask_in == 32'h1) ? 16'h0010 : 16'h0000);
endproperty
a_region_size: assert property (p_region_size)
    else $error("region size wrong");
property p_region_base;
    done_out |-> ext_region_base_out ==
        general_register_region_in - {48'h0, ext_region_size_out};
endproperty
a_region_base: assert property (p_region_base)
    else $error("region base wrong");
property p_page_align;
    past_ok_reg |-> page_info_aligned_out == (base_d_reg[4:0] == 5'h0);
endproperty
a_page_align: assert property (p_page_align)
    else $error("alignment flag wrong");
property p_page_fields;
    past_ok_reg |-> page_info_linear_addr_out == base_d_reg &&
        page_info_source_addr_out == base_d_reg + 64'h8 &&
        page_info_meta_addr_out == base_d_reg + 64'h10 &&
        page_info_ctrl_page_addr_out == base_d_reg + 64'h18;
endproperty
a_page_fields: assert property (p_page_fields)
    else $error("page field address wrong");
c_detail: cover property (mem_wr_out && mem_size_out == 4'h4);
c_sw_exit: cover property (exit_info_word_out[31] &&
    exit_info_word_out[10:8] == 3'h6);
c_refused: cover property (exit_start_in && busy_out);
endmodule : enclave_exit_fault_record_assertions
////////////////////////////////////////
bind enclave_exit_fault_record enclave_exit_fault_record_assertions
    i_enclave_exit_fault_record_assertions (
    .ref_clk_in,
    .rstn_in,
    .exit_start_in,
    .ext_capability_in,
    .component_select_mask_in,
    .general_register_region_in,
    .page_info_base_in,
    .page_info_aligned_out,
    .page_info_linear_addr_out,
    .page_info_source_addr_out,
    .page_info_meta_addr_out,
    .page_info_ctrl_page_addr_out,
    .exit_info_word_out,
    .ext_region_supported_out,
    .ext_region_size_out,
    .ext_region_base_out,
    .busy_out,
    .done_out,
    .mem_wr_out,
    .mem_size_out
);

//--- enclave_exit_fault_record_tb.sv
// self-checking bench for the exit fault record block
module enclave_exit_fault_record_tb;
timeunit 1ns;
timeprecision 100ps;
typedef struct packed
{
    logic [63:0] addr;
    logic [63:0] data;
    logic [3:0] size;
} store_t;
logic ref_clk_in, rstn_in = 1'b0, exit_start_in = 1'b0, software_exc_in = 1'b0;
logic shadow_stack_supported_in = 1'b0, branch_tracker_supported_in = 1'b0;
logic tracker_suppressed_in = 1'b0, awaiting_branch_target_in = 1'b0;
logic [7:0] vector_in = 8'h00;
logic [31:0] fault_error_code_in = 32'h0, ext_capability_in = 32'h0;
logic [31:0] component_select_mask_in = 32'h0, frame_count_in = 32'h0;
logic [31:0] current_frame_index_in = 32'h0;
logic [63:0] fault_linear_address_in = 64'h0, page_info_base_in = 64'h0;
logic [63:0] general_register_region_in = 64'h0, flow_area_offset_in = 64'h0;
logic [63:0] shadow_stack_pointer_in = 64'h0;
logic page_info_aligned_out, ext_region_supported_out, busy_out, done_out;
logic mem_wr_out;
logic [63:0] page_info_linear_addr_out, page_info_source_addr_out;
logic [63:0] page_info_meta_addr_out, page_info_ctrl_page_addr_out;
logic [63:0] ext_region_base_out, mem_addr_out, mem_data_out;
logic [31:0] exit_info_word_out;
logic [15:0] ext_region_size_out;
logic [3:0] mem_size_out;
store_t exp_q[$];
store_t cur;
logic [63:0] pb;
int miscompares = 0, checked = 0, cycles = 0;
logic [7:0] vecs [11] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h06, 8'h0d, 8'h0e,
    8'h10, 8'h11, 8'h13, 8'h15};
logic [7:0] others [9] = '{8'h02, 8'h04, 8'h07, 8'h08, 8'h0f, 8'h12, 8'h14,
    8'h1f, 8'hff};
logic [31:0] sels [5] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h8000_0001};
////////////////////////////////////////
enclave_exit_fault_record i_enclave_exit_fault_record (
    .ref_clk_in,
    .rstn_in,
    .exit_start_in,
    .vector_in,
    .software_exc_in,
    .fault_error_code_in,
    .fault_linear_address_in,
    .ext_capability_in,
    .component_select_mask_in,
    .general_register_region_in,
    .shadow_stack_supported_in,
    .branch_tracker_supported_in,
    .shadow_stack_pointer_in,
    .tracker_suppressed_in,
    .awaiting_branch_target_in,
    .frame_count_in,
    .current_frame_index_in,
    .flow_area_offset_in,
    .page_info_base_in,
    .page_info_aligned_out,
    .page_info_linear_addr_out,
    .page_info_source_addr_out,
    .page_info_meta_addr_out,
    .page_info_ctrl_page_addr_out,
    .exit_info_word_out,
    .ext_region_supported_out,
    .ext_region_size_out,
    .ext_region_base_out,
    .busy_out,
    .done_out,
    .mem_wr_out,
    .mem_addr_out,
    .mem_data_out,
    .mem_size_out
);
////////////////////////////////////////
task automatic chk(input string what, input logic [63:0] exp,
    input logic [63:0] got);
    checked++;
    if (got !== exp)
    begin
        $display("[ERR] %s expected %h seen %h", what, exp, got);
        miscompares++;
    end
endtask : chk
task conclude;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask : conclude
task automatic exit_case(input logic [7:0] vec, input logic sw,
    input logic [31:0] err, input logic [31:0] cap, input logic [31:0] sel,
    input logic poke);
    logic rep, det;
    logic [63:0] gpr, lin, fa, shadow_stack_pointer;
    logic [31:0] cnt, idx, word;
    logic [1:0] flg, sup;
    logic [15:0] size;
    int n;
    gpr = {$urandom, $urandom} & 64'hffff_ffff_ffff_fff0;
    lin = {$urandom, $urandom};
    shadow_stack_pointer = {$urandom, $urandom};
    cnt = $urandom % 4;
    idx = $urandom % 5;
    flg = 2'($urandom);
    sup = 2'($urandom);
    fa = {$urandom, $urandom};
    rep = (vec inside {8'h00, 8'h01, 8'h03, 8'h05, 8'h06, 8'h10, 8'h11,
        8'h13}) || (vec inside {8'h0d, 8'h0e} && sel[0]) ||
        (vec == 8'h15 && sel[1]);
    word = rep ? {1'b1, 20'h0, sw ? 3'h6 : 3'h3, vec} : 32'h0;
    det = ((vec == 8'h0d || (vec == 8'h0e && err[2])) && cap[0] && sel[0])
        || (vec == 8'h15 && cap[1] && sel[1]);
    size = (cap != 32'h0 && sel == 32'h1) ? 16'h0010 : 16'h0000;
    if (det)
    begin
        exp_q.push_back({gpr - 64'h10, vec == 8'h0e ? lin : 64'h0, 4'h8});
        exp_q.push_back({gpr - 64'h8, {32'h0, err}, 4'h4});
        exp_q.push_back({gpr - 64'h4, 64'h0, 4'h4});
    end
    if (idx < cnt && sup[0])
        exp_q.push_back({fa + {28'h0, idx, 4'h0}, shadow_stack_pointer, 4'h8});
    if (idx < cnt && sup[1])
        exp_q.push_back({fa + {28'h0, idx, 4'h8}, {62'h0, flg}, 4'h8});
    @(posedge ref_clk_in);
    vector_in <= vec;
    software_exc_in <= sw;
    fault_error_code_in <= err;
    fault_linear_address_in <= lin;
    ext_capability_in <= cap;
    component_select_mask_in <= sel;
    general_register_region_in <= gpr;
    shadow_stack_supported_in <= sup[0];
    branch_tracker_supported_in <= sup[1];
    shadow_stack_pointer_in <= shadow_stack_pointer;
    tracker_suppressed_in <= flg[0];
    awaiting_branch_target_in <= flg[1];
    frame_count_in <= cnt;
    current_frame_index_in <= idx;
    flow_area_offset_in <= fa;
    exit_start_in <= 1'b1;
    @(posedge ref_clk_in);
    exit_start_in <= 1'b0;
    @(posedge ref_clk_in);
    // a start while busy must leave the running exit untouched
    exit_start_in <= poke;
    if (poke)
        vector_in <= 8'h0e;
    @(posedge ref_clk_in);
    exit_start_in <= 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 20)
    begin
        @(posedge ref_clk_in);
        n++;
    end
    chk("done", 64'h1, {63'h0, done_out});
    chk("exit word", {32'h0, word}, {32'h0, exit_info_word_out});
    chk("region supported", {63'h0, cap != 32'h0},
        {63'h0, ext_region_supported_out});
    chk("region size", {48'h0, size}, {48'h0, ext_region_size_out});
    chk("region base", gpr - {48'h0, size}, ext_region_base_out);
    repeat (3) @(posedge ref_clk_in);
    chk("pending stores", 64'h0, 64'(exp_q.size()));
    $display("exit case vector %h done", vec);
endtask : exit_case
task automatic page_case(input logic [63:0] b);
    @(posedge ref_clk_in);
    page_info_base_in <= b;
    repeat (2) @(posedge ref_clk_in);
    chk("aligned", {63'h0, b[4:0] == 5'h0}, {63'h0, page_info_aligned_out});
    chk("linear field", b, page_info_linear_addr_out);
    chk("source field", b + 64'h8, page_info_source_addr_out);
    chk("meta field", b + 64'h10, page_info_meta_addr_out);
    chk("page field", b + 64'h18, page_info_ctrl_page_addr_out);
    $display("page case %h done", b);
endtask : page_case
////////////////////////////////////////
initial
begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
end
// stores are matched oldest first, so order errors show too
always @(posedge ref_clk_in)
begin
    if (rstn_in === 1'b1 && mem_wr_out === 1'b1)
    begin
        if (exp_q.size() == 0)
        begin
            $display("[ERR] store expected none seen %h", mem_addr_out);
            miscompares++;
        end
        else
        begin
            cur = exp_q.pop_front();
            chk("store address", cur.addr, mem_addr_out);
            chk("store data", cur.data, mem_data_out);
            chk("store size", {60'h0, cur.size}, {60'h0, mem_size_out});
        end
    end
    cycles++;
    if (cycles == 8000)
    begin
        miscompares++;
        conclude();
    end
end
initial
begin
    void'($urandom(15));
    repeat (16) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    foreach (vecs[i])
        exit_case(vecs[i], i % 2 == 1, $urandom | 32'h4, 32'h3, 32'h3, i == 5);
    foreach (vecs[i])
        exit_case(vecs[i], 1'b0, $urandom, 32'h3, 32'h0, 1'b0);
    foreach (others[i])
        exit_case(others[i], 1'b0, $urandom, 32'h3, 32'h3, 1'b0);
    exit_case(8'h0e, 1'b0, 32'hffff_fffb, 32'h1, 32'h1, 1'b0);
    exit_case(8'h0d, 1'b0, $urandom, 32'h0, 32'h1, 1'b0);
    exit_case(8'h15, 1'b0, $urandom, 32'h1, 32'h2, 1'b0);
    repeat (16)
        exit_case(vecs[$urandom % 11], 1'($urandom), $urandom,
            $urandom % 4, sels[$urandom % 5], 1'($urandom));
    for (int i = 0; i < 8; i++)
    begin
        pb = {$urandom, $urandom};
        if (i % 2 == 0)
            pb[4:0] = 5'h0;
        page_case(pb);
    end
    conclude();
end
endmodule : enclave_exit_fault_record_tb
